//--- design/cpu_register_set_psw.sv
// Architectural register state: general registers, program counter,
// system registers and the status word with flag update logic.
// Assumes the pipeline drives one request of each kind per cycle.
//
// Contract
// - Thirty-two GPRs, PC, system registers, 32-bit
// - PC bits 31..24 zero, carry dropped
// - PC bit 0 held zero
// - System registers numbered 0..5, 6..31 reserved
// - Exception or IRQ saves PC, status 0/1
// - NMI saves PC, status into 2/3
// - Cause: NMI code high, other low
// - Status word resets to 00000020h
// - Status bits 31..8 read zero
// - NMI sets bit 7, blocks nesting
// - Exception sets bit 6 and bit 5, IRQs blocked
// - Bit 5 blocks maskable interrupt acceptance
// - Clip flag sticky, cleared by status load
// - Plain arithmetic leaves clip flag alone
// - Bit 3 follows carry or borrow
// - Bit 2 follows overflow
// - Bit 1 follows negative result
// - Bit 0 follows zero result
// - Positive overflow clips to max, flags
// - Negative overflow clips to min, flags
// - In-range saturating result unmodified, overflow cleared
// - Overflow sets clip, clip from flags
// - Reset releases to port mode, ROM entry
`timescale 1ns/1ps
`include "cpu_regs_defines.svh"
module cpu_register_set_psw #(
  parameter logic [31:0] RESET_ENTRY = `PC_RESET
) (
  input wire logic clk_sys, // CPU clock, 200 MHz
  input wire logic resetn, // async reset, active low
  input wire logic [4:0] gprRaddrA, // GPR read address A
  input wire logic [4:0] gprRaddrB, // GPR read address B
  output logic [31:0] gprRdataA, // GPR read data A, registered
  output logic [31:0] gprRdataB, // GPR read data B, registered
  input wire logic gprWrEn, // GPR write strobe
  input wire logic [4:0] gprWaddr, // GPR write address
  input wire logic [31:0] gprWdata, // GPR write data
  input wire logic pcLoad, // load next PC
  input wire logic [31:0] pcNext, // next PC from branch/increment
  output logic [31:0] programCounter, // current PC, registered
  input wire logic sysWrEn, // load-system-register strobe
  input wire logic [4:0] sysWaddr, // system register number written
  input wire logic [31:0] sysWdata, // system register write data
  input wire logic [4:0] sysRaddr, // store-system-register number
  output logic [31:0] sysRdata, // system register read data
  input wire cpu_regs_pkg::event_t evtKind, // event taken this cycle
  input wire logic [15:0] evtCode, // cause code of the event
  input wire cpu_regs_pkg::flag_mode_t flagMode, // flag update kind
  input wire logic [31:0] aluResult, // raw ALU result
  input wire logic aluCarry, // carry or borrow out
  input wire logic aluOverflow, // signed overflow
  output logic [31:0] satResult, // result after saturation
  output logic [31:0] programStatusWord, // status word, registered
  output logic maskableIrqBlock, // maskable requests blocked
  output logic nestedBlock, // all nested acceptance blocked
  output logic portMode // bus pins in port mode
);
  logic [31:0] pc_r;
  logic [31:0] irqPc_r;
  logic [7:0] irqPsw_r;
  logic [31:0] nmiPc_r;
  logic [7:0] nmiPsw_r;
  logic [15:0] nmiCause_r;
  logic [15:0] excCause_r;
  logic [7:0] psw_r;
  logic [7:0] psw_nxt;
  logic [31:0] sysRdata_r;
  logic [31:0] satResult_r;
  logic [31:0] satValue;
  logic negFlag;
  logic clipHit;
  logic portMode_r;
  logic isMaskEvt;
  logic isNmiEvt;
  logic irqPcLoad;
  logic irqPswLoad;
  logic nmiPcLoad;
  logic nmiPswLoad;

  gpr_port_if gprBus ();

  assign gprBus.raddrA = gprRaddrA;
  assign gprBus.raddrB = gprRaddrB;
  assign gprBus.wrEn = gprWrEn;
  assign gprBus.waddr = gprWaddr;
  assign gprBus.wdata = gprWdata;
  assign gprRdataA = gprBus.rdataA;
  assign gprRdataB = gprBus.rdataB;

  gpr_file #(
    .DEPTH(32),
    .WIDTH(32)
  ) u_gpr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .port(gprBus.owner)
  );

  // Program counter: bits above 23 and bit 0 are forced to zero, so any
  // carry past bit 23 is simply dropped.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_r <= RESET_ENTRY & `PC_VALID_MASK;
    end else if (pcLoad) begin
      pc_r <= pcNext & `PC_VALID_MASK;
    end
  end

  // Pins come out of reset in port mode; the expansion register is elsewhere.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      portMode_r <= 1'b1;
    end else begin
      portMode_r <= portMode_r;
    end
  end

  // The event kinds are exclusive, so at most one save set captures an event per cycle.
  assign isMaskEvt = (evtKind == cpu_regs_pkg::EVT_EXCEPTION) ||
                     (evtKind == cpu_regs_pkg::EVT_MASKABLE);
  assign isNmiEvt = (evtKind == cpu_regs_pkg::EVT_NMI);

  // Software loads of the save registers. An event in the same cycle wins,
  // because the slot gives its capture strobe priority over the load.
  assign irqPcLoad = sysWrEn && (sysWaddr == `SR_IRQ_PC);
  assign irqPswLoad = sysWrEn && (sysWaddr == `SR_IRQ_PSW);
  assign nmiPcLoad = sysWrEn && (sysWaddr == `SR_NMI_PC);
  assign nmiPswLoad = sysWrEn && (sysWaddr == `SR_NMI_PSW);

  // Exception and interrupt save set; only one exists, so a nested
  // handler overwrites it unless software has copied it away.
  save_slot #(
    .WIDTH(32)
  ) u_irqPc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .capture(isMaskEvt),
    .captureData(pc_r),
    .load(irqPcLoad),
    .loadData(sysWdata),
    .value(irqPc_r)
  );

  save_slot #(
    .WIDTH(8)
  ) u_irqPsw (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .capture(isMaskEvt),
    .captureData(psw_r),
    .load(irqPswLoad),
    .loadData(sysWdata[7:0]),
    .value(irqPsw_r)
  );

  // The non-maskable save set is separate, so such an interrupt inside an
  // ordinary handler keeps the state that handler still has to return to.
  save_slot #(
    .WIDTH(32)
  ) u_nmiPc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .capture(isNmiEvt),
    .captureData(pc_r),
    .load(nmiPcLoad),
    .loadData(sysWdata),
    .value(nmiPc_r)
  );

  save_slot #(
    .WIDTH(8)
  ) u_nmiPsw (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .capture(isNmiEvt),
    .captureData(psw_r),
    .load(nmiPswLoad),
    .loadData(sysWdata[7:0]),
    .value(nmiPsw_r)
  );

  // The cause register is read-only to software; events alone update it.
  // Each half keeps its code until an event of its own kind replaces it.
  save_slot #(
    .WIDTH(16)
  ) u_nmiCause (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .capture(isNmiEvt),
    .captureData(evtCode),
    .load(1'b0),
    .loadData(16'h0000),
    .value(nmiCause_r)
  );

  save_slot #(
    .WIDTH(16)
  ) u_excCause (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .capture(isMaskEvt),
    .captureData(evtCode),
    .load(1'b0),
    .loadData(16'h0000),
    .value(excCause_r)
  );

  // Saturation: the clipped value is chosen from overflow and sign.
  assign negFlag = aluOverflow ? ~aluResult[31] : aluResult[31];
  assign clipHit = aluOverflow;
  always_comb begin
    satValue = aluResult;
    if (clipHit && !negFlag) begin
      satValue = `SAT_MAX_POS;
    end else if (clipHit && negFlag) begin
      satValue = `SAT_MAX_NEG;
    end
  end

  // Status word next value. Event bits win over a software load in the
  // same cycle, so an event is never lost.
  always_comb begin
    psw_nxt = psw_r;
    if (sysWrEn && sysWaddr == `SR_PSW) begin
      psw_nxt = sysWdata[7:0];
    end
    unique case (flagMode)
      cpu_regs_pkg::FLG_KEEP: begin
      end
      cpu_regs_pkg::FLG_ARITH: begin
        psw_nxt[`PSW_CARRY_BIT] = aluCarry;
        psw_nxt[`PSW_WRAP_BIT] = aluOverflow;
        psw_nxt[`PSW_NEG_BIT] = aluResult[31];
        psw_nxt[`PSW_ZERO_BIT] = (aluResult == 32'h00000000);
        // Clip flag intentionally untouched here.
      end
      cpu_regs_pkg::FLG_SAT: begin
        psw_nxt[`PSW_CARRY_BIT] = aluCarry;
        psw_nxt[`PSW_WRAP_BIT] = clipHit;
        psw_nxt[`PSW_NEG_BIT] = negFlag;
        psw_nxt[`PSW_ZERO_BIT] = (satValue == 32'h00000000);
        if (clipHit) begin
          psw_nxt[`PSW_CLIP_BIT] = 1'b1;
        end
      end
      default: begin
      end
    endcase
    unique case (evtKind)
      cpu_regs_pkg::EVT_NONE: begin
      end
      cpu_regs_pkg::EVT_EXCEPTION: begin
        psw_nxt[`PSW_FAULT_BIT] = 1'b1;
        psw_nxt[`PSW_IRQ_BLOCK_BIT] = 1'b1;
      end
      cpu_regs_pkg::EVT_MASKABLE: begin
        psw_nxt[`PSW_IRQ_BLOCK_BIT] = 1'b1;
      end
      cpu_regs_pkg::EVT_NMI: begin
        psw_nxt[`PSW_NMI_BIT] = 1'b1;
        psw_nxt[`PSW_IRQ_BLOCK_BIT] = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      psw_r <= `PSW_RESET;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      satResult_r <= 32'h00000000;
    end else begin
      satResult_r <= (flagMode == cpu_regs_pkg::FLG_SAT) ? satValue : aluResult;
    end
  end

  // Store-system-register read path; reserved numbers read zero.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sysRdata_r <= 32'h00000000;
    end else begin
      unique case (sysRaddr)
        `SR_IRQ_PC: sysRdata_r <= irqPc_r;
        `SR_IRQ_PSW: sysRdata_r <= {24'h000000, irqPsw_r};
        `SR_NMI_PC: sysRdata_r <= nmiPc_r;
        `SR_NMI_PSW: sysRdata_r <= {24'h000000, nmiPsw_r};
        `SR_CAUSE: sysRdata_r <= {nmiCause_r, excCause_r};
        `SR_PSW: sysRdata_r <= {24'h000000, psw_r};
        default: sysRdata_r <= 32'h00000000;
      endcase
    end
  end

  assign programCounter = pc_r;
  assign sysRdata = sysRdata_r;
  assign satResult = satResult_r;
  assign programStatusWord = {24'h000000, psw_r};
  assign maskableIrqBlock = psw_r[`PSW_IRQ_BLOCK_BIT] | psw_r[`PSW_NMI_BIT];
  assign nestedBlock = psw_r[`PSW_NMI_BIT];
  assign portMode = portMode_r;
endmodule : cpu_register_set_psw

// Holds one saved word. An event capture beats a software load in the
// same cycle, so the hardware snapshot is never lost to a stray store.
// One slot serves every save register, whatever its width.
module save_slot #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys, // CPU clock
  input wire logic resetn, // async reset, active low
  input wire logic capture, // event snapshot strobe
  input wire logic [WIDTH-1:0] captureData, // value saved on an event
  input wire logic load, // software load strobe
  input wire logic [WIDTH-1:0] loadData, // value loaded by software
  output logic [WIDTH-1:0] value // held word, registered
);
  logic [WIDTH-1:0] value_r;

  // Saved words start at zero; software must not trust them before an event.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      value_r <= '0;
    end else if (capture) begin
      value_r <= captureData;
    end else if (load) begin
      value_r <= loadData;
    end
  end

  assign value = value_r;
endmodule : save_slot

//--- design/cpu_regs_defines.svh
// Constants for the CPU architectural register set.
// Assumes inclusion by bare name from design files only.
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH
`define SR_IRQ_PC 5'h00
`define SR_IRQ_PSW 5'h01
`define SR_NMI_PC 5'h02
`define SR_NMI_PSW 5'h03
`define SR_CAUSE 5'h04
`define SR_PSW 5'h05
`define PSW_RESET 8'h20
`define PSW_NMI_BIT 7
`define PSW_FAULT_BIT 6
`define PSW_IRQ_BLOCK_BIT 5
`define PSW_CLIP_BIT 4
`define PSW_CARRY_BIT 3
`define PSW_WRAP_BIT 2
`define PSW_NEG_BIT 1
`define PSW_ZERO_BIT 0
`define PC_VALID_MASK 32'h00FFFFFE
`define PC_RESET 32'h00000000
`define SAT_MAX_POS 32'h7FFFFFFF
`define SAT_MAX_NEG 32'h80000000
`define CAUSE_HALF 16
`endif

//--- design/cpu_regs_pkg.sv
// Types shared by the register set modules.
// Assumes the constants header is available in the include path.
package cpu_regs_pkg;
  typedef enum logic [1:0] {
    EVT_NONE,
    EVT_EXCEPTION,
    EVT_MASKABLE,
    EVT_NMI
  } event_t;
  typedef enum logic [1:0] {
    FLG_KEEP,
    FLG_ARITH,
    FLG_SAT
  } flag_mode_t;
endpackage : cpu_regs_pkg

//--- design/gpr_port_if.sv
// Read and write ports of the general-purpose register file.
// Assumes one write port and two read ports on the CPU clock.
`timescale 1ns/1ps
interface gpr_port_if;
  logic [4:0] raddrA;
  logic [4:0] raddrB;
  logic [31:0] rdataA;
  logic [31:0] rdataB;
  logic wrEn;
  logic [4:0] waddr;
  logic [31:0] wdata;
  modport owner (input raddrA, raddrB, wrEn, waddr, wdata, output rdataA, rdataB);
  modport user (output raddrA, raddrB, wrEn, waddr, wdata, input rdataA, rdataB);
endinterface : gpr_port_if

//--- design/gpr_file.sv
// Thirty-two word general-purpose register memory with registered reads.
// Assumes synchronous use on clk_sys with active-low async reset.
`timescale 1ns/1ps
module gpr_file #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 32
) (
  input wire logic clk_sys, // CPU clock
  input wire logic resetn, // async reset, active low
  gpr_port_if.owner port // register file ports
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdataA_r;
  logic [WIDTH-1:0] rdataB_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (port.wrEn && port.waddr != 5'h00) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  // Register zero is forced on read so a stray write can never surface.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdataA_r <= '0;
      rdataB_r <= '0;
    end else begin
      rdataA_r <= (port.raddrA == 5'h00) ? '0 : mem[port.raddrA];
      rdataB_r <= (port.raddrB == 5'h00) ? '0 : mem[port.raddrB];
    end
  end

  assign port.rdataA = rdataA_r;
  assign port.rdataB = rdataB_r;
endmodule : gpr_file

//--- verif/cpu_register_set_psw_monitor.sv
// Concurrent checks on the register set top-level ports.
// Assumes it is bound onto cpu_register_set_psw.
`timescale 1ns/1ps
module cpu_register_set_psw_checker (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic [4:0] gprRaddrA, // read address
  input wire logic [31:0] gprRdataA, // read data
  input wire logic pcLoad, // pc load
  input wire logic [31:0] pcNext, // next pc
  input wire logic [31:0] programCounter, // pc
  input wire logic sysWrEn, // sys write
  input wire cpu_regs_pkg::event_t evtKind, // event
  input wire cpu_regs_pkg::flag_mode_t flagMode, // flag mode
  input wire logic [31:0] aluResult, // alu result
  input wire logic aluCarry, // carry
  input wire logic aluOverflow, // overflow
  input wire logic [31:0] satResult, // clipped
  input wire logic [31:0] programStatusWord, // status
  input wire logic maskableIrqBlock, // irq block
  input wire logic nestedBlock // nest block
);
  logic [3:0] arithFlags;
  logic [2:0] satFlags;
  logic satOvf;
  assign arithFlags = {aluCarry, aluOverflow, aluResult[31], aluResult == 32'h0};
  assign satFlags = {programStatusWord[4], programStatusWord[2], programStatusWord[1]};
  assign satOvf = flagMode == cpu_regs_pkg::FLG_SAT && aluOverflow;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  zero_reg_a: assert property (
    gprRaddrA == 5'h00 |=> gprRdataA == 32'h0) else $error("zero register not zero");
  pc_mask_a: assert property (
    pcLoad |=> programCounter == ($past(pcNext) & 32'h00FFFFFE)) else $error("pc mask");
  psw_upper_a: assert property (
    programStatusWord[31:8] == 24'h0) else $error("status upper bits set");
  nmi_entry_a: assert property (
    evtKind == cpu_regs_pkg::EVT_NMI |=> programStatusWord[7] && nestedBlock)
    else $error("nmi flag missing");
  exc_entry_a: assert property (
    evtKind == cpu_regs_pkg::EVT_EXCEPTION |=> programStatusWord[6]) else $error("fault flag");
  irq_gate_a: assert property (
    maskableIrqBlock == (programStatusWord[5] || programStatusWord[7])) else $error("irq gate");
  sat_pos_a: assert property (
    satOvf && aluResult[31] |=> satResult == 32'h7FFFFFFF && satFlags == 3'b110)
    else $error("positive clip");
  sat_neg_a: assert property (
    satOvf && !aluResult[31] |=> satResult == 32'h80000000 && satFlags == 3'b111)
    else $error("negative clip");
  arith_flags_a: assert property (
    flagMode == cpu_regs_pkg::FLG_ARITH |=> programStatusWord[3:0] == $past(arithFlags))
    else $error("arith flags");
  clip_keep_a: assert property (
    flagMode == cpu_regs_pkg::FLG_ARITH && !sysWrEn |=> $stable(programStatusWord[4]))
    else $error("clip flag moved");
  cover property (satOvf);
  cover property (evtKind == cpu_regs_pkg::EVT_NMI);
  cover property (sysWrEn && programStatusWord[4]);
endmodule : cpu_register_set_psw_checker
bind cpu_register_set_psw cpu_register_set_psw_checker i_checker (
  .clk_sys(clk_sys), .resetn(resetn), .gprRaddrA(gprRaddrA), .gprRdataA(gprRdataA),
  .pcLoad(pcLoad), .pcNext(pcNext), .programCounter(programCounter), .sysWrEn(sysWrEn),
  .evtKind(evtKind), .flagMode(flagMode), .aluResult(aluResult), .aluCarry(aluCarry),
  .aluOverflow(aluOverflow), .satResult(satResult), .programStatusWord(programStatusWord),
  .maskableIrqBlock(maskableIrqBlock), .nestedBlock(nestedBlock));

//--- verif/cpu_register_set_psw_bench.sv
// Self-checking bench for the CPU register set and status word.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
module cpu_register_set_psw_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] gprRaddrA = 5'h00, gprRaddrB = 5'h00, gprWaddr = 5'h00;
  logic [4:0] sysWaddr = 5'h00, sysRaddr = 5'h00;
  logic gprWrEn = 1'b0, pcLoad = 1'b0, sysWrEn = 1'b0, aluCarry = 1'b0, aluOverflow = 1'b0;
  logic [31:0] gprWdata = 32'h0, pcNext = 32'h0, sysWdata = 32'h0, aluResult = 32'h0;
  logic [15:0] evtCode = 16'h0000;
  cpu_regs_pkg::event_t evtKind = cpu_regs_pkg::EVT_NONE;
  cpu_regs_pkg::flag_mode_t flagMode = cpu_regs_pkg::FLG_KEEP;
  logic [31:0] gprRdataA, gprRdataB, programCounter, sysRdata, satResult, programStatusWord;
  logic maskableIrqBlock, nestedBlock, portMode;
  int nMismatch = 0;
  int nChecks = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  cpu_register_set_psw i_dut (.clk_sys(clk_sys), .resetn(resetn), .gprRaddrA(gprRaddrA),
    .gprRaddrB(gprRaddrB), .gprRdataA(gprRdataA), .gprRdataB(gprRdataB), .gprWrEn(gprWrEn),
    .gprWaddr(gprWaddr), .gprWdata(gprWdata), .pcLoad(pcLoad), .pcNext(pcNext),
    .programCounter(programCounter), .sysWrEn(sysWrEn), .sysWaddr(sysWaddr),
    .sysWdata(sysWdata), .sysRaddr(sysRaddr), .sysRdata(sysRdata), .evtKind(evtKind),
    .evtCode(evtCode), .flagMode(flagMode), .aluResult(aluResult), .aluCarry(aluCarry),
    .aluOverflow(aluOverflow), .satResult(satResult), .programStatusWord(programStatusWord),
    .maskableIrqBlock(maskableIrqBlock), .nestedBlock(nestedBlock), .portMode(portMode));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nChecks++;
    if (seen !== want) begin
      nMismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wrapUp();
    if (nMismatch == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrapUp
  // Each task drives at a falling edge and leaves its strobe low again,
  // so results are settled when it returns.
  task automatic sysWr(input logic [4:0] n, input logic [31:0] d);
    @(negedge clk_sys);
    sysWrEn = 1'b1;
    sysWaddr = n;
    sysWdata = d;
    @(negedge clk_sys);
    sysWrEn = 1'b0;
  endtask : sysWr
  task automatic sysRd(input logic [4:0] n, input logic [31:0] want);
    @(negedge clk_sys);
    sysRaddr = n;
    @(negedge clk_sys);
    check(sysRdata, want);
  endtask : sysRd
  task automatic gprChk(input logic [4:0] a, input logic [31:0] d, input logic [31:0] want);
    @(negedge clk_sys);
    gprWrEn = 1'b1;
    gprWaddr = a;
    gprWdata = d;
    gprRaddrA = a;
    gprRaddrB = a;
    @(negedge clk_sys);
    gprWrEn = 1'b0;
    @(negedge clk_sys);
    check(gprRdataA, want);
    check(gprRdataB, want);
  endtask : gprChk
  task automatic pc(input logic [31:0] v);
    @(negedge clk_sys);
    pcLoad = 1'b1;
    pcNext = v;
    @(negedge clk_sys);
    pcLoad = 1'b0;
  endtask : pc
  task automatic evt(input cpu_regs_pkg::event_t k, input logic [15:0] code);
    @(negedge clk_sys);
    evtKind = k;
    evtCode = code;
    @(negedge clk_sys);
    evtKind = cpu_regs_pkg::EVT_NONE;
  endtask : evt
  task automatic alu(input cpu_regs_pkg::flag_mode_t m, input logic [31:0] r, input logic c,
                     input logic o, input logic [31:0] wantSat, input logic [7:0] wantPsw);
    @(negedge clk_sys);
    flagMode = m;
    aluResult = r;
    aluCarry = c;
    aluOverflow = o;
    @(negedge clk_sys);
    flagMode = cpu_regs_pkg::FLG_KEEP;
    check(satResult, wantSat);
    check(programStatusWord, {24'h0, wantPsw});
  endtask : alu
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      wrapUp();
    end
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    check(programStatusWord, 32'h00000020);
    check(programCounter, 32'h0);
    check({31'h0, portMode}, 32'h1);
    gprChk(5'h00, 32'hFFFFFFFF, 32'h0);
    gprChk(5'h1F, 32'hA5A5A5A5, 32'hA5A5A5A5);
    pc(32'hFFFFFFFF);
    check(programCounter, 32'h00FFFFFE);
    pc(32'h00001235);
    for (int n = 0; n < 32; n++) begin
      sysWr(5'(n), 32'h1234565A);
      sysRd(5'(n), (n == 0 || n == 2) ? 32'h1234565A : (n == 4 || n > 5) ? 32'h0 : 32'h5A);
    end
    sysWr(5'h05, 32'h0);
    evt(cpu_regs_pkg::EVT_EXCEPTION, 16'h1234);
    check(programStatusWord, 32'h00000060);
    check({31'h0, maskableIrqBlock}, 32'h1);
    sysRd(5'h00, 32'h00001234);
    sysRd(5'h01, 32'h0);
    sysWr(5'h05, 32'h0);
    evt(cpu_regs_pkg::EVT_MASKABLE, 16'h00AB);
    sysRd(5'h04, 32'h000000AB);
    evt(cpu_regs_pkg::EVT_NMI, 16'h0012);
    check(programStatusWord, 32'h000000A0);
    check({31'h0, nestedBlock}, 32'h1);
    sysRd(5'h02, 32'h00001234);
    sysRd(5'h03, 32'h00000020);
    sysRd(5'h04, 32'h001200AB);
    sysWr(5'h05, 32'h0);
    check({31'h0, maskableIrqBlock}, 32'h0);
    alu(cpu_regs_pkg::FLG_SAT, 32'h80000000, 1'b0, 1'b1, 32'h7FFFFFFF, 8'h14);
    alu(cpu_regs_pkg::FLG_ARITH, 32'h0, 1'b0, 1'b0, 32'h0, 8'h11);
    alu(cpu_regs_pkg::FLG_SAT, 32'h7FFFFFFF, 1'b0, 1'b1, 32'h80000000, 8'h16);
    alu(cpu_regs_pkg::FLG_SAT, 32'h5, 1'b1, 1'b0, 32'h5, 8'h18);
    alu(cpu_regs_pkg::FLG_ARITH, 32'h80000000, 1'b1, 1'b1, 32'h80000000, 8'h1E);
    sysWr(5'h05, 32'h0);
    check(programStatusWord, 32'h0);
    // The bench never moves a mode setting, so port mode must still hold.
    check({31'h0, portMode}, 32'h1);
    wrapUp();
  end
endmodule : cpu_register_set_psw_bench
